// ==== src/switch_mode_control.sv ====
// Switch mode control: debounced switches drive controller modes and channels
`timescale 1ns/1ps
`default_nettype none
module switch_mode_control
  import mode_ctrl_pkg::*;
#(
  parameter int DEB_CYC = mode_ctrl_pkg::DEBOUNCE_CYC,
  parameter int WDT_CYCLES = mode_ctrl_pkg::WDT_CYC
)(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic park_button_n,
  input wire logic [7:0] mode_switch_bank,
  input wire logic ref_clk_in,
  output logic ref_clk_out,
  output logic park_float_n,
  output logic bias_float,
  output logic watchdog_en_n,
  output logic mirror_reset_pulse,
  output logic row_addr_mode,
  output logic [1:0] block_mode,
  output logic two_block_reset_sel_n,
  output logic vertical_flip_out,
  output logic complement_out,
  output logic [15:0] chan_a_pos_bus,
  output logic [15:0] chan_a_neg_bus,
  output logic chan_a_pos_clock,
  output logic chan_a_neg_clock,
  output logic chan_a_pos_valid,
  output logic chan_a_neg_valid,
  output logic [15:0] chan_b_pos_bus,
  output logic [15:0] chan_b_neg_bus,
  output logic chan_b_pos_clock,
  output logic chan_b_neg_clock,
  output logic chan_b_pos_valid,
  output logic chan_b_neg_valid,
  output logic [15:0] chan_c_pos_bus,
  output logic [15:0] chan_c_neg_bus,
  output logic chan_c_pos_clock,
  output logic chan_c_neg_clock,
  output logic chan_c_pos_valid,
  output logic chan_c_neg_valid,
  output logic [15:0] chan_d_pos_bus,
  output logic [15:0] chan_d_neg_bus,
  output logic chan_d_pos_clock,
  output logic chan_d_neg_clock,
  output logic chan_d_pos_valid,
  output logic chan_d_neg_valid,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int NIN = SW_BITS + 1;
  localparam int DW = $clog2(DEB_CYC + 1);
  localparam int WW = $clog2(WDT_CYCLES + 1);

  // Counts the logic cannot serve are refused
  if (DEB_CYC < 2 || WDT_CYCLES < 2) begin : g_bad_param
    $error("DEB_CYC and WDT_CYCLES must be at least 2");
  end

  logic [NIN-1:0] raw_s1_r, raw_s2_r, deb_r;
  logic [DW-1:0] deb_cnt_r [NIN];
  logic [2:0] ref_sync_r;
  park_state_e park_st_r, park_st_nxt;
  logic [PAT_W-1:0] pat_cnt_r;
  logic [WW-1:0] wdt_cnt_r;
  logic run_r, sw_mrst_r;
  logic [CHAN_W-1:0] pos_bus_r [CHANS];
  logic [CHAN_W-1:0] neg_bus_r [CHANS];
  logic [CHANS-1:0] pos_clk_r, neg_clk_r, pos_val_r, neg_val_r;
  logic aw_held_r, w_held_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;

  // Two flops on every pin before the debouncer looks at it
  always_ff @(posedge clk)
  begin
    raw_s1_r <= {~park_button_n, mode_switch_bank};
    raw_s2_r <= raw_s1_r;
    ref_sync_r <= {ref_sync_r[1:0], ref_clk_in};
  end

  // Per-input debounce: accept a new level only after DEB_CYC steady cycles
  for (genvar i = 0; i < NIN; i++) begin : g_deb
    always_ff @(posedge clk)
    begin
      if (sys_rst)
      begin
        deb_r[i] <= 1'b0;
        deb_cnt_r[i] <= '0;
      end
      else if (raw_s2_r[i] == deb_r[i])
        deb_cnt_r[i] <= '0; // Bounce restarts the wait
      else if (deb_cnt_r[i] == DW'(DEB_CYC - 1))
      begin
        deb_r[i] <= raw_s2_r[i];
        deb_cnt_r[i] <= '0;
      end
      else
        deb_cnt_r[i] <= deb_cnt_r[i] + 1'b1;
    end
  end

  wire [SW_BITS-1:0] sw_db = deb_r[SW_BITS-1:0];
  wire park_press = deb_r[SW_BITS];
  wire parked = (park_st_r != PK_IDLE);
  wire wdt_on = sw_db[SW_WDT];
  wire wdt_fire = wdt_on && (wdt_cnt_r == WW'(WDT_CYCLES - 1));
  wire park_rst = (park_st_r == PK_RESET);
  wire mrst_any = wdt_fire || sw_mrst_r || park_rst;
  wire count_en = run_r && !sw_db[SW_HALT] && !parked;
  wire stream_on = count_en && !sw_db[SW_FLOAT];

  // Park sequence: one mirror reset, then float, then stay parked
  always_comb
  begin
    case (park_st_r)
      PK_IDLE: park_st_nxt = park_press ? PK_RESET : PK_IDLE;
      PK_RESET: park_st_nxt = PK_FLOAT;
      PK_FLOAT: park_st_nxt = PK_PARKED;
      PK_PARKED: park_st_nxt = PK_PARKED; // Only reset leaves it
      default: park_st_nxt = PK_IDLE;
    endcase
  end

  // Modes, watchdog and pattern counter; sys_rst stands in for power cycling
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      park_st_r <= PK_IDLE;
      pat_cnt_r <= '0;
      wdt_cnt_r <= '0;
      park_float_n <= 1'b1;
      bias_float <= 1'b0;
      watchdog_en_n <= 1'b1;
      mirror_reset_pulse <= 1'b0;
      row_addr_mode <= 1'b0;
      block_mode <= 2'h0;
      two_block_reset_sel_n <= 1'b1;
      vertical_flip_out <= 1'b0;
      complement_out <= 1'b0;
      ref_clk_out <= 1'b0;
    end
    else
    begin
      park_st_r <= park_st_nxt;
      if (count_en)
        pat_cnt_r <= pat_cnt_r + 1'b1; // Frozen while halted
      // Any mirror reset restarts the interval
      wdt_cnt_r <= (mrst_any || !wdt_on) ? '0 : wdt_cnt_r + 1'b1;
      park_float_n <= !(park_st_r == PK_FLOAT || park_st_r == PK_PARKED);
      bias_float <= sw_db[SW_FLOAT];
      watchdog_en_n <= !wdt_on;
      mirror_reset_pulse <= mrst_any;
      row_addr_mode <= sw_db[SW_ROWMODE];
      block_mode <= sw_db[SW_RTYPE_LO +: 2];
      two_block_reset_sel_n <= (sw_db[SW_RTYPE_LO +: 2] != RTYPE_DUAL);
      vertical_flip_out <= sw_db[SW_FLIP];
      complement_out <= sw_db[SW_COMP];
      ref_clk_out <= ref_sync_r[1];
    end
  end

  // Channel drivers: a data word per clock, link clock toggles every cycle
  for (genvar c = 0; c < CHANS; c++) begin : g_chan
    always_ff @(posedge clk)
    begin
      if (sys_rst)
      begin
        pos_bus_r[c] <= '0;
        neg_bus_r[c] <= '1;
        pos_clk_r[c] <= 1'b0;
        neg_clk_r[c] <= 1'b1;
        pos_val_r[c] <= 1'b0;
        neg_val_r[c] <= 1'b1;
      end
      else
      begin
        pos_bus_r[c] <= pat_cnt_r[CHAN_W-1:0] ^ {4{4'(c)}};
        neg_bus_r[c] <= ~(pat_cnt_r[CHAN_W-1:0] ^ {4{4'(c)}});
        pos_clk_r[c] <= ~pos_clk_r[c];
        neg_clk_r[c] <= pos_clk_r[c];
        pos_val_r[c] <= stream_on;
        neg_val_r[c] <= !stream_on;
      end
    end
  end

  assign chan_a_pos_bus = pos_bus_r[0];
  assign chan_a_neg_bus = neg_bus_r[0];
  assign chan_a_pos_clock = pos_clk_r[0];
  assign chan_a_neg_clock = neg_clk_r[0];
  assign chan_a_pos_valid = pos_val_r[0];
  assign chan_a_neg_valid = neg_val_r[0];
  assign chan_b_pos_bus = pos_bus_r[1];
  assign chan_b_neg_bus = neg_bus_r[1];
  assign chan_b_pos_clock = pos_clk_r[1];
  assign chan_b_neg_clock = neg_clk_r[1];
  assign chan_b_pos_valid = pos_val_r[1];
  assign chan_b_neg_valid = neg_val_r[1];
  assign chan_c_pos_bus = pos_bus_r[2];
  assign chan_c_neg_bus = neg_bus_r[2];
  assign chan_c_pos_clock = pos_clk_r[2];
  assign chan_c_neg_clock = neg_clk_r[2];
  assign chan_c_pos_valid = pos_val_r[2];
  assign chan_c_neg_valid = neg_val_r[2];
  assign chan_d_pos_bus = pos_bus_r[3];
  assign chan_d_neg_bus = neg_bus_r[3];
  assign chan_d_pos_clock = pos_clk_r[3];
  assign chan_d_neg_clock = neg_clk_r[3];
  assign chan_d_pos_valid = pos_val_r[3];
  assign chan_d_neg_valid = neg_val_r[3];

  // Register decode; only the low lane holds control bits
  wire wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
  wire wr_ctrl = wr_go && (awaddr_r == CTRL_OFS) && wstrb_r[0];
  wire wr_hit = (awaddr_r == CTRL_OFS) || (awaddr_r == STATUS_OFS)
    || (awaddr_r == COUNT_OFS);
  wire rd_go = s_axi_arvalid && s_axi_arready;
  wire rd_hit = (s_axi_araddr == CTRL_OFS) || (s_axi_araddr == STATUS_OFS)
    || (s_axi_araddr == COUNT_OFS);
  wire [31:0] stat_word = {22'h0, bias_float, parked, sw_db};
  wire [31:0] rd_word = (s_axi_araddr == STATUS_OFS) ? stat_word
    : (s_axi_araddr == COUNT_OFS) ? {5'h0, pat_cnt_r}
    : (s_axi_araddr == CTRL_OFS) ? {31'h0, run_r} : 32'h0000_0000;

  // AXI4-Lite slave: address and data taken in either order, one at a time
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      run_r <= CTRL_RUN_RST;
      sw_mrst_r <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      sw_mrst_r <= wr_ctrl && wdata_r[CTRL_MRST_BIT];
      if (wr_ctrl)
        run_r <= wdata_r[CTRL_RUN_BIT];
      if (wr_go)
      begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      // Read accepted only while no answer is pending
      s_axi_arready <= !s_axi_rvalid && !rd_go;
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Checks kept beside the logic
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_park_go;
    park_st_r == PK_IDLE && park_press;
  endsequence
  sequence s_park_steps;
    ##1 park_rst ##1 (park_st_r == PK_FLOAT) ##1 (park_st_r == PK_PARKED);
  endsequence

  a_park_sequence: assert property (s_park_go |-> s_park_steps)
    else $error("park sequence out of order");
  a_park_held: assert property (parked |=> parked [*8])
    else $error("park state left without reset");
  a_park_float_out: assert property (park_st_r == PK_PARKED |=> !park_float_n)
    else $error("power float not driven while parked");
  a_wdt_expiry: assert property (wdt_fire |=> mirror_reset_pulse ##1 wdt_cnt_r == 1)
    else $error("watchdog expiry missed");
  // The first edge after reset still shows the reset values, so it is skipped
  a_row_mode_out: assert property (!$past(sys_rst)
    |-> row_addr_mode == $past(sw_db[SW_ROWMODE]))
    else $error("row mode not following switch");
  a_reset_type_out: assert property (!$past(sys_rst)
    |-> block_mode == $past(sw_db[5:4]))
    else $error("reset type not following switches");
  a_dual_select: assert property (two_block_reset_sel_n == (block_mode != RTYPE_DUAL))
    else $error("dual block select mismatch");
  a_flip_comp: assert property (!$past(sys_rst) |-> {vertical_flip_out, complement_out}
    == $past(sw_db[SW_FLIP:SW_COMP]))
    else $error("flip or complement not following switches");
  a_halt_freeze: assert property (sw_db[SW_HALT] |=> $stable(pat_cnt_r))
    else $error("pattern counter moved while halted");
  a_float_release: assert property ($fell(sw_db[SW_FLOAT]) |=> !bias_float)
    else $error("bias float not released");
  a_debounce_wait: assert property ($changed(deb_r[0])
    |-> $past(deb_cnt_r[0]) == DW'(DEB_CYC - 1))
    else $error("debounced level changed early");
  a_ref_forward: assert property (!$past(sys_rst)
    |-> ref_clk_out == $past(ref_sync_r[1]))
    else $error("reference clock not forwarded");
  a_chan_clock: assert property (!$past(sys_rst) |-> pos_clk_r[0] != $past(pos_clk_r[0])
    && chan_a_neg_valid == !chan_a_pos_valid)
    else $error("channel clock or valid pair wrong");
endmodule
`default_nettype wire

// ==== include/mode_ctrl_pkg.sv ====
// Constants shared by the switch mode control block
package mode_ctrl_pkg;
  // Register byte offsets
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] COUNT_OFS = 8'h04;
  localparam logic [7:0] CTRL_OFS = 8'h08;
  // Control register fields and reset value
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_MRST_BIT = 1;
  localparam logic CTRL_RUN_RST = 1'b1;
  // Status register fields
  localparam int STAT_PARK_BIT = 8;
  localparam int STAT_FLOAT_BIT = 9;
  // Mode switch bit positions
  localparam int SW_FLOAT = 0;
  localparam int SW_HALT = 1;
  localparam int SW_COMP = 2;
  localparam int SW_FLIP = 3;
  localparam int SW_RTYPE_LO = 4;
  localparam int SW_ROWMODE = 6;
  localparam int SW_WDT = 7;
  localparam int SW_BITS = 8;
  localparam logic [1:0] RTYPE_DUAL = 2'h1;
  // Widths
  localparam int PAT_W = 27;
  localparam int CHAN_W = 16;
  localparam int CHANS = 4;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Timing
  localparam int CLK_HZ = 20_000_000;
  localparam int DEBOUNCE_US = 4000;
  localparam int DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1_000_000);
  localparam int WDT_S = 10;
  localparam int WDT_CYC = WDT_S * CLK_HZ;
  // Park command sequence states
  typedef enum logic [1:0] {
    PK_IDLE = 2'b00,
    PK_RESET = 2'b01,
    PK_FLOAT = 2'b10,
    PK_PARKED = 2'b11
  } park_state_e;
endpackage

// ==== tb/mirror_ctrl_model.sv ====
// Behavioural model of the mirror array controller on the far side
`timescale 1ns/1ps
`default_nettype none
module mirror_ctrl_model
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [63:0] pos_bus,
  input wire logic [63:0] neg_bus,
  input wire logic [3:0] pos_clk,
  input wire logic [3:0] neg_clk,
  input wire logic [3:0] pos_vld,
  input wire logic [3:0] neg_vld,
  input wire logic ref_clk,
  input wire logic reset_pulse,
  output int n_reset,
  output int n_ref,
  output int n_bad
);
  logic ref_q;
  logic [3:0] clk_q;
  logic live;
  // Counts resets and reference edges; flags lanes that are not clean pairs
  // Checks skip the first edge after reset, when the lane clocks have not moved yet
  always @(posedge clk)
  begin
    ref_q <= ref_clk;
    clk_q <= pos_clk;
    live <= !sys_rst;
    if (sys_rst)
    begin
      n_reset <= 0;
      n_ref <= 0;
      n_bad <= 0;
    end
    else
    begin
      if (reset_pulse)
        n_reset <= n_reset + 1;
      if (ref_clk && !ref_q)
        n_ref <= n_ref + 1;
      if (live && (neg_bus !== ~pos_bus || neg_clk !== ~pos_clk || neg_vld !== ~pos_vld
          || pos_clk !== ~clk_q || pos_bus[63:16] !== ({3{pos_bus[15:0]}} ^ 48'h3333_2222_1111)))
        n_bad <= n_bad + 1;
    end
  end
endmodule
`default_nettype wire

// ==== tb/switch_mode_control_tb_top.sv ====
// Self-checking bench for the switch mode control block
`timescale 1ns/1ps
`default_nettype none
module switch_mode_control_tb_top;
  import mode_ctrl_pkg::*;
  localparam int DEB = 4;
  localparam int WDT = 50;
  logic clk, sys_rst, park_n, ref_in, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] sw, awaddr, araddr, s;
  logic [31:0] wdata, v, v2;
  logic [1:0] r;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp, blk;
  wire [31:0] rdata;
  wire [15:0] pa, na, pb, nb, pc, nc, pd, nd;
  wire [3:0] pk, nk, pv, nv;
  wire ref_out, pfloat_n, bfloat, wdt_n, mrst, rowm, two_n, flip, comp;
  int n_mismatch, n_compared, n_rst, n_ref, n_bad, cyc_n, t;

  switch_mode_control #(.DEB_CYC(DEB), .WDT_CYCLES(WDT)) uut (
    .clk(clk), .sys_rst(sys_rst), .park_button_n(park_n), .mode_switch_bank(sw),
    .ref_clk_in(ref_in), .ref_clk_out(ref_out), .park_float_n(pfloat_n), .bias_float(bfloat),
    .watchdog_en_n(wdt_n), .mirror_reset_pulse(mrst), .row_addr_mode(rowm), .block_mode(blk),
    .two_block_reset_sel_n(two_n), .vertical_flip_out(flip), .complement_out(comp),
    .chan_a_pos_bus(pa), .chan_a_neg_bus(na), .chan_a_pos_clock(pk[0]),
    .chan_a_neg_clock(nk[0]), .chan_a_pos_valid(pv[0]), .chan_a_neg_valid(nv[0]),
    .chan_b_pos_bus(pb), .chan_b_neg_bus(nb), .chan_b_pos_clock(pk[1]),
    .chan_b_neg_clock(nk[1]), .chan_b_pos_valid(pv[1]), .chan_b_neg_valid(nv[1]),
    .chan_c_pos_bus(pc), .chan_c_neg_bus(nc), .chan_c_pos_clock(pk[2]),
    .chan_c_neg_clock(nk[2]), .chan_c_pos_valid(pv[2]), .chan_c_neg_valid(nv[2]),
    .chan_d_pos_bus(pd), .chan_d_neg_bus(nd), .chan_d_pos_clock(pk[3]),
    .chan_d_neg_clock(nk[3]), .chan_d_pos_valid(pv[3]), .chan_d_neg_valid(nv[3]),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  mirror_ctrl_model far_end (.clk(clk), .sys_rst(sys_rst), .pos_bus({pd, pc, pb, pa}),
    .neg_bus({nd, nc, nb, na}), .pos_clk(pk), .neg_clk(nk), .pos_vld(pv), .neg_vld(nv),
    .ref_clk(ref_out), .reset_pulse(mrst), .n_reset(n_rst), .n_ref(n_ref), .n_bad(n_bad));

  // Bench clock and a free-running reference unrelated in phase
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    ref_in = 1'b0;
    #7;
    forever #200 ref_in = ~ref_in;
  end

  task automatic tally_and_finish;
    if (n_mismatch == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Cuts a hang short; the full run needs well under two thousand cycles
  always @(posedge clk)
  begin
    cyc_n++;
    if (cyc_n == 6000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Ready is read mid-cycle, where it equals its value at the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rsp);
    logic ta, tw, tb;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    while (!tb)
    begin
      @(negedge clk);
      ta = awready;
      tw = wready;
      tb = bvalid;
      rsp = bresp;
      @(posedge clk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
    end
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rsp);
    logic ta, tr;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tr = 1'b0;
    while (!tr)
    begin
      @(negedge clk);
      ta = arready;
      tr = rvalid;
      d = rdata;
      rsp = rresp;
      @(posedge clk);
      if (ta)
        arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // Main sequence
  initial
  begin
    {sys_rst, park_n, sw, awaddr, araddr, wdata, awvalid, wvalid} = {1'b1, 1'b1, 58'h0};
    {bready, arvalid, rready} = 3'h0;
    cyc(2);
    sys_rst <= 1'b0;
    cyc(1);
    chk("park_float_n", 1, pfloat_n);
    chk("two_block_n", 1, two_n);
    // Every reset type, row mode, flip and complement bits alternating
    for (int k = 0; k < 4; k++)
    begin
      s = 8'(k << 4) | (k[0] ? 8'h4C : 8'h00);
      sw <= s;
      cyc(20);
      chk("row_mode", s[6], rowm);
      chk("block_mode", s[5:4], blk);
      chk("two_block_n", s[5:4] != RTYPE_DUAL, two_n);
      chk("flip", s[3], flip);
      chk("complement", s[2], comp);
      rd(STATUS_OFS, v, r);
      chk("status_sw", s, v[7:0]);
    end
    // A short glitch must never reach the output
    sw <= 8'h78;
    cyc(2);
    sw <= 8'h7C;
    repeat (12)
    begin
      @(negedge clk);
      chk("glitch", 1, comp);
    end
    @(posedge clk);
    sw <= 8'h78;
    cyc(DEB);
    chk("deb_early", 1, comp);
    cyc(8);
    chk("deb_late", 0, comp);
    // Halt freezes the pattern counter and drops valid
    sw <= 8'h02;
    cyc(20);
    rd(COUNT_OFS, v, r);
    cyc(10);
    rd(COUNT_OFS, v2, r);
    chk("count_halt", v, v2);
    chk("valid_halt", 0, pv[0]);
    sw <= 8'h01;
    cyc(20);
    rd(COUNT_OFS, v, r);
    chk("count_runs", 1, v !== v2);
    chk("bias_float", 1, bfloat);
    chk("valid_float", 0, pv[0]);
    sw <= 8'h00;
    cyc(20);
    chk("bias_float", 0, bfloat);
    chk("valid_run", 1, pv[0]);
    // Watchdog pulses only while enabled
    sw <= 8'h80;
    cyc(20);
    chk("wdt_en_n", 0, wdt_n);
    t = n_rst;
    cyc(4 * WDT);
    chk("wdt_pulses", 1, (n_rst - t) inside {3, 4});
    sw <= 8'h00;
    cyc(20);
    chk("wdt_dis_n", 1, wdt_n);
    t = n_rst;
    cyc(4 * WDT);
    chk("wdt_off", 0, n_rst - t);
    // Software mirror reset and an unmapped place
    wr(CTRL_OFS, 32'h0000_0003, r);
    cyc(3);
    chk("sw_reset", 1, n_rst - t);
    chk("ctrl_resp", RESP_OKAY, r);
    wr(8'h0C, 32'h0000_0001, r);
    chk("bad_wr", RESP_SLVERR, r);
    rd(8'h0C, v, r);
    chk("bad_rd", {2'h0, RESP_SLVERR}, {v[1:0], r});
    t = n_ref;
    cyc(100);
    chk("ref_edges", 1, (n_ref - t) inside {12, 13});
    chk("lane_pairs", 0, n_bad);
    // Park is one-way until the next reset
    t = n_rst;
    park_n <= 1'b0;
    cyc(20);
    park_n <= 1'b1;
    cyc(60);
    chk("parked", 0, pfloat_n);
    chk("park_reset", 1, n_rst - t);
    rd(STATUS_OFS, v, r);
    chk("status_park", 1, v[STAT_PARK_BIT]);
    sys_rst <= 1'b1;
    cyc(2);
    sys_rst <= 1'b0;
    cyc(1);
    chk("unparked", 1, pfloat_n);
    tally_and_finish();
  end
endmodule
`default_nettype wire
